// File: common/tce_pkg.sv
// constants for the tick calibration and interrupt enable slice
// assumes a 32-bit AXI4-Lite register port with an 8-bit byte address
package tce_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0]  OFF_TICK_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_TICK_RELOAD   = 8'h04;
	localparam logic [7:0]  OFF_TICK_CURRENT  = 8'h08;
	localparam logic [7:0]  OFF_TICK_CALIB    = 8'h0c;
	localparam logic [7:0]  OFF_IRQ_SET_LOW   = 8'h10;
	localparam logic [7:0]  OFF_IRQ_CLEAR_LOW = 8'h14;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int          CTRL_ENABLE_BIT   = 0;
	localparam int          CTRL_CPUCLK_BIT   = 2;
	localparam int          CTRL_FLAG_BIT     = 16;
	localparam int          COUNT_W           = 24;
	localparam logic        NO_REF_VALUE      = 1'h0;
	localparam logic        INEXACT_VALUE     = 1'h0;
	localparam logic [23:0] TEN_MS_VALUE      = 24'h0009c4;
	localparam logic [31:0] CALIB_WORD        = {NO_REF_VALUE, INEXACT_VALUE, 6'h00, TEN_MS_VALUE};
	localparam logic [30:0] IRQ_IMPL_MASK     = 31'h7fffdfff;
	localparam logic [30:0] IRQ_RESET         = 31'h00000000;
	localparam logic [23:0] COUNT_RESET       = 24'h000000;

	// ****************************************
	// timing and bus answers
	// ****************************************
	localparam int          REF_DIVIDE        = 32;
	localparam logic [4:0]  REF_LAST          = 5'(REF_DIVIDE - 1);
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef enum logic {TMR_IDLE, TMR_RUN} tce_tmr_state_t;

endpackage

// File: dv/tb_tce_regs.sv
// self-checking bench for the register slice: calibration word, enables, tick timer
// assumes tce_regs alone on an AXI4-Lite bus driven by the tasks below
`timescale 1ns/1ps
module tb_tce_regs
	import tce_pkg::*;
;
	// ****************************************
	// signals and design instance
	// ****************************************
	logic        refClk;
	logic        rstN;
	logic [7:0]  awAddr;
	logic        awValid;
	logic        awReady;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        wValid;
	logic        wReady;
	logic [1:0]  bResp;
	logic        bValid;
	logic        bReady;
	logic [7:0]  arAddr;
	logic        arValid;
	logic        arReady;
	logic [31:0] rData;
	logic [1:0]  rResp;
	logic        rValid;
	logic        rReady;
	logic [30:0] irqEnable;
	logic        tickExpired;
	int          errTotal;
	int          checked;
	logic [31:0] rv;
	logic [1:0]  rs;
	int          gap;

	tce_regs u_tce_regs (
		.ref_clk       (refClk),
		.rst_n         (rstN),
		.s_axi_awaddr  (awAddr),
		.s_axi_awvalid (awValid),
		.s_axi_awready (awReady),
		.s_axi_wdata   (wData),
		.s_axi_wstrb   (wStrb),
		.s_axi_wvalid  (wValid),
		.s_axi_wready  (wReady),
		.s_axi_bresp   (bResp),
		.s_axi_bvalid  (bValid),
		.s_axi_bready  (bReady),
		.s_axi_araddr  (arAddr),
		.s_axi_arvalid (arValid),
		.s_axi_arready (arReady),
		.s_axi_rdata   (rData),
		.s_axi_rresp   (rResp),
		.s_axi_rvalid  (rValid),
		.s_axi_rready  (rReady),
		.irqEnable     (irqEnable),
		.tickExpired   (tickExpired)
	);

	initial
	begin
		refClk = 1'b0;
		forever #50 refClk = ~refClk;
	end

	// ****************************************
	// checks and closing
	// ****************************************
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			errTotal++;
		end
	endtask

	task automatic hung();
		errTotal++;
		end_sim();
	endtask

	// ****************************************
	// bus tasks
	// ****************************************
	// handshakes are judged at the falling edge, where inputs are settled and
	// equal to what the next rising edge samples, so no process-order race
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] resp);
		int n;
		logic aw, w, b;
		@(posedge refClk);
		awAddr  <= a;
		wData   <= d;
		wStrb   <= s;
		awValid <= 1'b1;
		wValid  <= 1'b1;
		bReady  <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 50 && !b; n++)
		begin
			@(negedge refClk);
			aw = awValid && awReady;
			w = wValid && wReady;
			b = bValid;
			resp = bResp;
			@(posedge refClk);
			if (aw) awValid <= 1'b0;
			if (w) wValid <= 1'b0;
			if (b) bReady <= 1'b0;
		end
		if (!b) hung();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		logic ar, r;
		@(posedge refClk);
		arAddr  <= a;
		arValid <= 1'b1;
		rReady  <= 1'b1;
		r = 1'b0;
		for (n = 0; n < 50 && !r; n++)
		begin
			@(negedge refClk);
			ar = arValid && arReady;
			r = rValid;
			d = rData;
			resp = rResp;
			@(posedge refClk);
			if (ar) arValid <= 1'b0;
			if (r) rReady <= 1'b0;
		end
		if (!r) hung();
	endtask

	// cycles between two expiry pulses; the first pulse found may belong to an older setting
	task automatic tick_gap(output int n);
		int k;
		k = 0;
		@(negedge refClk);
		while (tickExpired !== 1'b1 && k < 400)
		begin
			@(negedge refClk);
			k++;
		end
		n = 0;
		do
		begin
			@(negedge refClk);
			n++;
		end while (tickExpired !== 1'b1 && n < 400);
		if (k >= 400 || n >= 400) hung();
	endtask

	task automatic reset_dut();
		@(posedge refClk);
		rstN <= 1'b0;
		repeat (2) @(posedge refClk);
		rstN <= 1'b1;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		errTotal = 0;
		checked = 0;
		rstN = 1'b0;
		{awAddr, awValid, wData, wStrb, wValid, bReady} = '0;
		{arAddr, arValid, rReady} = '0;
		repeat (2) @(posedge refClk);
		rstN <= 1'b1;
		@(negedge refClk);
		chk({1'b0, irqEnable}, 32'h00000000);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h00000000);
		rd(OFF_TICK_CALIB, rv, rs);
		chk(rv, 32'h000009c4);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		wr(OFF_TICK_CALIB, 32'hffffffff, 4'hf, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		rd(OFF_TICK_CALIB, rv, rs);
		chk(rv, 32'h000009c4);
		wr(OFF_IRQ_SET_LOW, 32'h00000005, 4'hf, rs);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h00000005);
		wr(OFF_IRQ_SET_LOW, 32'h00000002, 4'hf, rs);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h00000007);
		wr(OFF_IRQ_SET_LOW, 32'h00000000, 4'hf, rs);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h00000007);
		wr(OFF_IRQ_SET_LOW, 32'hffffffff, 4'hf, rs);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h7fffdfff);
		chk({1'b0, irqEnable}, 32'h7fffdfff);
		wr(OFF_IRQ_CLEAR_LOW, 32'hffffffff, 4'hf, rs);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h00000000);
		wr(OFF_IRQ_SET_LOW, 32'hffffffff, 4'h1, rs);
		rd(OFF_IRQ_SET_LOW, rv, rs);
		chk(rv, 32'h000000ff);
		wr(8'h40, 32'h00000001, 4'hf, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		rd(8'h40, rv, rs);
		chk(rv, 32'h00000000);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		// second reset in mid-run must drop the enables again
		reset_dut();
		@(negedge refClk);
		chk({1'b0, irqEnable}, 32'h00000000);
		// periodic use: reload is the wanted period minus one
		wr(OFF_TICK_RELOAD, 32'h00000003, 4'hf, rs);
		rd(OFF_TICK_RELOAD, rv, rs);
		chk(rv, 32'h00000003);
		wr(OFF_TICK_CTRL, 32'h00000005, 4'hf, rs);
		tick_gap(gap);
		tick_gap(gap);
		chk(32'(gap), 32'd4);
		wr(OFF_TICK_CTRL, 32'h00000001, 4'hf, rs);
		tick_gap(gap);
		tick_gap(gap);
		chk(32'(gap), 32'd128);
		// count flag is up after the expiries and drops on its own read
		rd(OFF_TICK_CTRL, rv, rs);
		chk(rv, 32'h00010001);
		rd(OFF_TICK_CTRL, rv, rs);
		chk(rv, 32'h00000001);
		end_sim();
	end
endmodule

// File: hdl/tce_regs.sv
// register slice: tick timer control, calibration word, interrupt enables
// assumes an AXI4-Lite master; one write and one read at most in flight
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module tce_regs
	import tce_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	output logic [30:0]       irqEnable,
	output logic              tickExpired
);

	logic                awHeld;
	logic [7:0]          awAddr;
	logic                wHeld;
	logic [31:0]         wData;
	logic [3:0]          wStrb;
	logic                wrFire;
	logic                arFire;
	logic [31:0]         wrMask;
	logic [31:0]         setBits;
	logic [31:0]         clrBits;
	logic                ctrlEnable;
	logic                ctrlCpuClk;
	logic                countFlag;
	logic [COUNT_W-1:0]  reloadValue;
	logic [COUNT_W-1:0]  current;
	logic                clearCurrent;
	logic [7:0]          rdAddr;

	function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
		regHit = (addr[7:2] == off[7:2]);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = regHit(addr, OFF_TICK_CTRL) || regHit(addr, OFF_TICK_RELOAD)
			|| regHit(addr, OFF_TICK_CURRENT) || regHit(addr, OFF_TICK_CALIB)
			|| regHit(addr, OFF_IRQ_SET_LOW) || regHit(addr, OFF_IRQ_CLEAR_LOW);
	endfunction

	// ****************************************
	// write channel
	// ****************************************
	assign s_axi_awready = !awHeld;
	assign s_axi_wready  = !wHeld;
	assign wrFire        = awHeld && wHeld && !s_axi_bvalid;
	assign wrMask        = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
	assign setBits       = (wrFire && regHit(awAddr, OFF_IRQ_SET_LOW)) ? (wData & wrMask) : 32'h0;
	assign clrBits       = (wrFire && regHit(awAddr, OFF_IRQ_CLEAR_LOW)) ? (wData & wrMask) : 32'h0;
	assign clearCurrent  = wrFire && regHit(awAddr, OFF_TICK_CURRENT) && (wStrb != 4'h0);

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
		end
		else if (s_axi_awvalid && !awHeld)
		begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end
		else if (wrFire)
			awHeld <= 1'b0;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			wHeld <= 1'b0;
			wData <= 32'h0;
			wStrb <= 4'h0;
		end
		else if (s_axi_wvalid && !wHeld)
		begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end
		else if (wrFire)
			wHeld <= 1'b0;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wrFire)
		begin
			s_axi_bvalid <= 1'b1;
			// the calibration word is read-only; writes to it are dropped quietly
			s_axi_bresp  <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;

	// ****************************************
	// tick control and reload
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			ctrlEnable <= 1'b0;
			ctrlCpuClk <= 1'b0;
		end
		else if (wrFire && regHit(awAddr, OFF_TICK_CTRL) && wStrb[0])
		begin
			ctrlEnable <= wData[CTRL_ENABLE_BIT];
			ctrlCpuClk <= wData[CTRL_CPUCLK_BIT];
		end

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			reloadValue <= COUNT_RESET;
		else if (wrFire && regHit(awAddr, OFF_TICK_RELOAD))
			reloadValue <= (reloadValue & ~wrMask[23:0]) | (wData[23:0] & wrMask[23:0]);

	// a new expiry wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			countFlag <= 1'b0;
		else if (tickExpired)
			countFlag <= 1'b1;
		else if ((arFire && regHit(s_axi_araddr, OFF_TICK_CTRL)) || clearCurrent)
			countFlag <= 1'b0;

	tce_tick_timer u_tce_tick_timer (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.enable       (ctrlEnable),
		.useCpuClk    (ctrlCpuClk),
		.reloadValue  (reloadValue),
		.clearCurrent (clearCurrent),
		.current      (current),
		.countedZero  (tickExpired)
	);

	// ****************************************
	// interrupt enables
	// ****************************************
	for (genvar i = 0; i < 31; i++)
	begin : g_irq
		if (IRQ_IMPL_MASK[i])
		begin : g_impl
			always_ff @(posedge ref_clk or negedge rst_n)
				if (!rst_n)
					irqEnable[i] <= IRQ_RESET[i];
				else if (setBits[i])
					irqEnable[i] <= 1'b1;
				else if (clrBits[i])
					irqEnable[i] <= 1'b0;
		end
		else
		begin : g_none
			assign irqEnable[i] = 1'b0;
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;
	assign arFire        = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
			rdAddr       <= 8'h00;
		end
		else if (arFire)
		begin
			s_axi_rvalid <= 1'b1;
			rdAddr       <= s_axi_araddr;
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata  <= 32'h0;
			if (regHit(s_axi_araddr, OFF_TICK_CTRL))
				s_axi_rdata <= {15'h0, countFlag, 13'h0, ctrlCpuClk, 1'b0, ctrlEnable};
			else if (regHit(s_axi_araddr, OFF_TICK_RELOAD))
				s_axi_rdata <= {8'h00, reloadValue};
			else if (regHit(s_axi_araddr, OFF_TICK_CURRENT))
				s_axi_rdata <= {8'h00, current};
			else if (regHit(s_axi_araddr, OFF_TICK_CALIB))
				s_axi_rdata <= CALIB_WORD;
			else if (regHit(s_axi_araddr, OFF_IRQ_SET_LOW) || regHit(s_axi_araddr, OFF_IRQ_CLEAR_LOW))
				s_axi_rdata <= {1'b0, irqEnable};
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;

	// ****************************************
	// checks
	// ****************************************
	property p_calib_flags;
		@(posedge ref_clk) disable iff (!rst_n)
		(s_axi_rvalid && regHit(rdAddr, OFF_TICK_CALIB)) |-> s_axi_rdata[31:30] == 2'h0;
	endproperty
	a_calib_flags: assert property (p_calib_flags) else $error("calibration flags not zero");

	property p_calib_exact;
		@(posedge ref_clk) disable iff (!rst_n)
		(arFire && regHit(s_axi_araddr, OFF_TICK_CALIB)) |=> !s_axi_rdata[30] && s_axi_rvalid;
	endproperty
	a_calib_exact: assert property (p_calib_exact) else $error("inexact flag set");

	property p_calib_count;
		@(posedge ref_clk) disable iff (!rst_n)
		(arFire && regHit(s_axi_araddr, OFF_TICK_CALIB))
			|=> s_axi_rdata[29:0] == 30'h000009c4 && s_axi_rresp == RESP_OKAY;
	endproperty
	a_calib_count: assert property (p_calib_count) else $error("calibration count wrong");

	property p_set_enables;
		@(posedge ref_clk) disable iff (!rst_n)
		(setBits != 32'h0) |=> ({1'b0, irqEnable} & $past(setBits) & {1'b0, IRQ_IMPL_MASK})
			== ($past(setBits) & {1'b0, IRQ_IMPL_MASK});
	endproperty
	a_set_enables: assert property (p_set_enables) else $error("set write did not enable");

	property p_zero_keeps;
		@(posedge ref_clk) disable iff (!rst_n)
		(clrBits == 32'h0) |=> (irqEnable & $past(irqEnable)) == $past(irqEnable);
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("enable lost without clear");

	property p_read_state;
		@(posedge ref_clk) disable iff (!rst_n)
		(arFire && regHit(s_axi_araddr, OFF_IRQ_SET_LOW)) |=> s_axi_rdata == {1'b0, $past(irqEnable)};
	endproperty
	a_read_state: assert property (p_read_state) else $error("enable readback wrong");

	property p_holes;
		@(posedge ref_clk) disable iff (!rst_n)
		s_axi_rvalid && regHit(rdAddr, OFF_IRQ_SET_LOW) |-> !s_axi_rdata[31] && !s_axi_rdata[13];
	endproperty
	a_holes: assert property (p_holes) else $error("unimplemented enable reads one");

	// no disable here: this one must look at the reset cycles themselves
	property p_reset_clear;
		@(posedge ref_clk)
		(!rst_n || $rose(rst_n)) |-> irqEnable == 31'h0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("enable set out of reset");

	c_set_write: cover property (@(posedge ref_clk) disable iff (!rst_n) setBits != 32'h0);
	c_clr_write: cover property (@(posedge ref_clk) disable iff (!rst_n) clrBits != 32'h0);
	c_calib_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
		arFire && regHit(s_axi_araddr, OFF_TICK_CALIB));

endmodule

// File: hdl/tce_tick_timer.sv
// tick down-counter with the divide-by-32 reference prescaler
// assumes ref_clk is the oscillator clock and also serves as the cpu clock
`timescale 1ns/1ps
module tce_tick_timer
	import tce_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                enable,
	input  wire logic                useCpuClk,
	input  wire logic [COUNT_W-1:0]  reloadValue,
	input  wire logic                clearCurrent,
	output logic      [COUNT_W-1:0]  current,
	output logic                     countedZero
);

	tce_tmr_state_t  state;
	logic [4:0]      refCnt;
	logic            refTick;
	logic            step;

	// ****************************************
	// reference clock prescaler
	// ****************************************
	// free running so the reference phase never depends on software
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			refCnt <= 5'h00;
		else
			refCnt <= refCnt + 5'h01;

	assign refTick = (refCnt == REF_LAST);
	assign step    = useCpuClk ? 1'b1 : refTick;

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			state       <= TMR_IDLE;
			current     <= COUNT_RESET;
			countedZero <= 1'b0;
		end
		else
		begin
			countedZero <= 1'b0;
			case (state)
				TMR_IDLE:
					if (enable)
					begin
						state   <= TMR_RUN;
						current <= reloadValue;
					end
					else if (clearCurrent)
						current <= COUNT_RESET;
				TMR_RUN:
					if (!enable)
						state <= TMR_IDLE;
					else if (clearCurrent)
						current <= COUNT_RESET;
					else if (step)
					begin
						if (current == COUNT_RESET)
							current <= reloadValue;
						else
							current <= current - 24'h000001;
						countedZero <= (current == 24'h000001);
					end
				default:
					state <= TMR_IDLE;
			endcase
		end

	// ****************************************
	// checks
	// ****************************************
	property p_ref_period;
		@(posedge ref_clk) disable iff (!rst_n)
		refTick |=> !refTick [*8];
	endproperty
	a_ref_period: assert property (p_ref_period) else $error("reference tick too close");

	property p_reload_at_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		(state == TMR_RUN && enable && !clearCurrent && step && current == COUNT_RESET)
			|=> current == $past(reloadValue);
	endproperty
	a_reload_at_zero: assert property (p_reload_at_zero) else $error("no reload at zero");

	c_reload: cover property (@(posedge ref_clk) disable iff (!rst_n) countedZero);

endmodule
